// ==== src/multiqueue_write_port_select.sv ====
`timescale 1ns/1ps
// Overview of operation
// R1: write enable stores data into selected queue
// R2: queue strobe latches write queue address
// R3: writer strobes only when changing queue
// R4: strobe never held permanently high
// R5: never both strobes in one cycle
// R6: no queue strobe before config done
// R7: direct mode: sector strobe picks flag sector
// R8: polled mode steps flag bus through sectors
// R9: polled mode sync marker on write clock
// R10: flags updated only on write clock
// R11: expansion flags timed on write clock
// R12: write clock runs continuously
// R13: low bits queue, high bits device id
// R14: new queue written from second edge
// R15: config done output low when programmed
// R16: both strobes together are ignored
module multiqueue_write_port_select (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] deviceId,
    input wire logic polledMode,
    input wire logic configDone_n,
    input wire logic writeEnable,
    input wire logic [mq_write_pkg::DATA_W-1:0] writeData,
    input wire logic queueSelectStrobe,
    input wire logic flagSectorStrobe,
    input wire logic [mq_write_pkg::ADDR_W-1:0] writeQueueAddress,
    input wire logic [mq_write_pkg::NUM_QUEUES-1:0] queueDrain,
    input wire logic flagExpansionInput,
    output logic configDoneOutput_n,
    output logic fullFlag_n,
    output logic almostFullFlag_n,
    output logic [mq_write_pkg::FLAG_BUS_W-1:0] almostFullFlagBus_n,
    output logic flagBusSyncMarker,
    output logic flagExpansionOutput,
    output logic writeAccepted,
    output logic outValid,
    input wire logic outReady,
    output logic [mq_write_pkg::DATA_W-1:0] outData,
    output logic [mq_write_pkg::QUEUE_BITS-1:0] outQueue
);
    localparam int QB = mq_write_pkg::QUEUE_BITS;
    localparam int NQ = mq_write_pkg::NUM_QUEUES;
    localparam int CW = mq_write_pkg::CNT_W;
    localparam int FW = mq_write_pkg::FLAG_BUS_W;
    localparam int DW = mq_write_pkg::DATA_W;

    ////////////////////////////////////////////////////////////////////////////
    // state, pin synchronisers included
    typedef struct packed {
        logic [1:0] cfgSync;
        logic [1:0] fxiSync;
        logic [1:0] modeSync;
        logic [QB-1:0] queue;
        logic [QB-1:0] pendQueue;
        logic [1:0] pendAge;
        logic selected;
        logic pendSelected;
        logic sector;
        logic pollPhase;
        logic [NQ-1:0][CW-1:0] level;
        logic fullN;
        logic almostN;
        logic [FW-1:0] busN;
        logic sync;
        logic flag_expansion_output;
        logic cfgOut;
        logic accepted;
    } wp_state_t;
    wp_state_t st;
    wp_state_t next_st;
    logic cfgReady;
    logic fxiSynced;
    logic polled;
    // only the second stage of each pin synchroniser feeds logic
    assign cfgReady = !st.cfgSync[1];
    assign fxiSynced = st.fxiSync[1];
    assign polled = st.modeSync[1];

    // queue address is for us when the device field matches our id
    function automatic logic addr_hits(input logic [mq_write_pkg::ADDR_W-1:0] a,
                                       input logic [2:0] id);
        return a[mq_write_pkg::DEV_LSB +: mq_write_pkg::DEV_BITS] == id; // R13
    endfunction

    function automatic logic is_full(input logic [CW-1:0] lvl);
        return lvl == CW'(mq_write_pkg::QUEUE_DEPTH);
    endfunction

    function automatic logic is_almost(input logic [CW-1:0] lvl);
        return lvl >= CW'(mq_write_pkg::QUEUE_DEPTH - mq_write_pkg::ALMOST_FULL_MARGIN);
    endfunction

    logic fifoReady;
    logic doWrite;
    logic bothStrobes;
    logic [QB-1:0] sel;
    logic sectorNow;
    assign bothStrobes = queueSelectStrobe && flagSectorStrobe; // R16
    assign doWrite = writeEnable && st.selected && cfgReady && fifoReady
        && !is_full(st.level[st.queue]);

    always_comb begin
        next_st = st;
        next_st.accepted = doWrite;
        next_st.cfgSync = {st.cfgSync[0], configDone_n};
        next_st.fxiSync = {st.fxiSync[0], flagExpansionInput};
        next_st.modeSync = {st.modeSync[0], polledMode};
        // queue selection, effective two edges later
        if (queueSelectStrobe && !bothStrobes && cfgReady) begin // R2 R6 R16
            next_st.pendQueue = writeQueueAddress[QB-1:0]; // R13
            next_st.pendSelected = addr_hits(writeQueueAddress, deviceId);
            next_st.pendAge = mq_write_pkg::PIPE_DEPTH - 2'h1;
        end else if (st.pendAge != 2'h0) begin
            next_st.pendAge = st.pendAge - 2'h1;
            if (st.pendAge == 2'h1) begin // R14
                next_st.queue = st.pendQueue;
                next_st.selected = st.pendSelected;
            end
        end
        if (flagSectorStrobe && !bothStrobes && !polled
            && addr_hits(writeQueueAddress, deviceId)) begin // R7 R16
            next_st.sector = writeQueueAddress[0];
        end
        // occupancy per queue; drains come from the read side
        for (int q = 0; q < NQ; q++) begin
            if (doWrite && st.queue == QB'(q) && !queueDrain[q]) begin // R1
                next_st.level[q] = st.level[q] + 1'b1;
            end else if (!(doWrite && st.queue == QB'(q)) && queueDrain[q]
                && st.level[q] != '0) begin
                next_st.level[q] = st.level[q] - 1'b1;
            end
        end
        next_st.pollPhase = polled ? !st.pollPhase : 1'b0; // R8
        sectorNow = polled ? st.pollPhase : st.sector;
        for (int b = 0; b < FW; b++) begin
            sel = {sectorNow, 3'(b)};
            next_st.busN[b] = !is_almost(next_st.level[sel]); // R10
        end
        next_st.sync = polled && !st.pollPhase; // R9
        next_st.fullN = !(st.selected && is_full(next_st.level[st.queue])); // R10
        next_st.almostN = !(st.selected && is_almost(next_st.level[st.queue]));
        // expansion: pass our full status merged with the upstream device
        next_st.flag_expansion_output = fxiSynced && next_st.fullN; // R11
        next_st.cfgOut = st.cfgSync[1]; // R15
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.queue <= mq_write_pkg::QUEUE_RESET;
            st.sector <= mq_write_pkg::SECTOR_RESET;
            st.fullN <= 1'b1;
            st.almostN <= 1'b1;
            st.busN <= '1;
            st.flag_expansion_output <= 1'b1;
            st.cfgOut <= 1'b1;
            // idle pin levels; mode resets to direct so no sync pulse follows reset
            st.cfgSync <= 2'h3;
            st.fxiSync <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data path: selected queue tag travels with each word
    mq_stream_fifo #(
        .WIDTH(DW + QB),
        .DEPTH(mq_write_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(doWrite),
        .inReady(fifoReady),
        .inData({st.queue, writeData}),
        .outValid(outValid),
        .outReady(outReady),
        .outData({outQueue, outData})
    );

    assign configDoneOutput_n = st.cfgOut;
    assign fullFlag_n = st.fullN;
    assign almostFullFlag_n = st.almostN;
    assign almostFullFlagBus_n = st.busN;
    assign flagBusSyncMarker = st.sync;
    assign flagExpansionOutput = st.flag_expansion_output;
    assign writeAccepted = st.accepted;
endmodule // multiqueue_write_port_select

// ==== src/mq_write_pkg.sv ====
package mq_write_pkg;
    localparam int DATA_W = 36;
    localparam int ADDR_W = 7;
    localparam int QUEUE_BITS = 4;
    localparam int NUM_QUEUES = 16;
    localparam int DEV_LSB = 4;
    localparam int DEV_BITS = 3;
    localparam int SECTOR_BITS = 1;
    localparam int FLAG_BUS_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int QUEUE_DEPTH = 8;
    localparam int CNT_W = 4;
    localparam int ALMOST_FULL_MARGIN = 2;
    localparam logic [QUEUE_BITS-1:0] QUEUE_RESET = 4'h0;
    localparam logic SECTOR_RESET = 1'b0;
    localparam logic [1:0] PIPE_DEPTH = 2'h2;
endpackage

// ==== src/mq_stream_fifo.sv ====
`timescale 1ns/1ps
module mq_stream_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0] count;
    } fifo_state_t;
    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;
    // the count needs one bit more than a pointer to tell full from empty
    assign inReady = st.count != (PW+1)'(DEPTH);
    assign outValid = st.count != '0;
    assign outData = st.mem[st.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = st.wrPtr + 1'b1;
        end
        if (pop) begin
            next_st.rdPtr = st.rdPtr + 1'b1;
        end
        next_st.count = st.count + (PW+1)'(push) - (PW+1)'(pop);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // mq_stream_fifo

// ==== verification/mq_write_props.sv ====
`timescale 1ns/1ps
module mq_write_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic polledMode,
    input wire logic writeEnable,
    input wire logic writeAccepted,
    input wire logic outValid,
    input wire logic configDoneOutput_n,
    input wire logic fullFlag_n,
    input wire logic flagBusSyncMarker,
    input wire logic flagExpansionOutput
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_accept_cause: assert property (writeAccepted |-> $past(writeEnable))
        else $error("accept without enable");
    a_accept_valid: assert property (writeAccepted |-> outValid)
        else $error("accepted word not offered");
    a_config_gate: assert property (configDoneOutput_n |-> !writeAccepted)
        else $error("write before config done");
    a_full_refuses: assert property (!fullFlag_n && !$past(fullFlag_n) |-> !writeAccepted)
        else $error("write taken while full");
    a_sync_pulse: assert property (flagBusSyncMarker |=> !flagBusSyncMarker)
        else $error("sync marker too long");
    a_sync_period: assert property (flagBusSyncMarker && polledMode |-> ##2 flagBusSyncMarker)
        else $error("flag bus not stepping");
    a_sync_mode: assert property (flagBusSyncMarker |-> $past(polledMode, 2) || $past(polledMode, 3))
        else $error("sync outside polled mode");
    a_exp_full: assert property (!fullFlag_n [*3] |-> !flagExpansionOutput)
        else $error("expansion flag misses full");
endmodule // mq_write_props
bind multiqueue_write_port_select mq_write_props mq_write_props_i (.*);

// ==== verification/mq_sink_model.sv ====
`timescale 1ns/1ps
module mq_sink_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic slow,
    output logic outReady
);
    // slow mode takes a word every other cycle so the buffer backs up
    logic phase;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) phase <= 1'b0;
        else phase <= ~phase;
    end
    assign outReady = !stall && (!slow || phase);
endmodule // mq_sink_model

// ==== verification/tb_multiqueue_write_port_select.sv ====
`timescale 1ns/1ps
`define CHK(n, e, a) begin samplesChecked++; if ((a) !== (e)) begin numErrors++; \
    $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb_multiqueue_write_port_select;
    logic clk = 0, rst = 1, polledMode = 0, configDone_n = 1, writeEnable = 0, stall = 0;
    logic queueSelectStrobe = 0, flagSectorStrobe = 0, flagExpansionInput = 1, slow = 0;
    logic [2:0] deviceId = 3'h5;
    logic [35:0] writeData = 36'h0, outData;
    logic [6:0] writeQueueAddress = 7'h0;
    logic [15:0] queueDrain = 16'h0;
    logic configDoneOutput_n, fullFlag_n, almostFullFlag_n, flagBusSyncMarker;
    logic flagExpansionOutput, writeAccepted, outValid, outReady;
    logic [7:0] almostFullFlagBus_n;
    logic [3:0] outQueue;
    logic [39:0] exp[$], w;
    int numErrors = 0, samplesChecked = 0, accCnt = 0, a;
    multiqueue_write_port_select multiqueue_write_port_select_i (.*);
    mq_sink_model mq_sink_model_i (.*);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (writeAccepted === 1'b1) accCnt++;
        if (outValid === 1'b1 && outReady === 1'b1) begin
            w = exp.pop_front();
            `CHK("word", w, {outQueue, outData})
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic step; @(posedge clk); #1; endtask
    task automatic closeOut;
        $display("checked %0d errors %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] q, input logic ok);
        writeEnable = 1;
        writeData = writeData + 36'h1;
        if (ok) exp.push_back({q, writeData});
        step;
    endtask
    // strobe only in the change cycle, and only after config is done
    task automatic sel(input logic [6:0] ad);
        queueSelectStrobe = 1;
        writeQueueAddress = ad;
        step;
        queueSelectStrobe = 0;
        step;
    endtask
    task automatic sec(input logic [6:0] ad, input logic [7:0] e);
        flagSectorStrobe = 1;
        writeQueueAddress = ad;
        step;
        flagSectorStrobe = 0;
        repeat (2) step;
        `CHK("sector", e, almostFullFlagBus_n)
    endtask
    task automatic drain;
        for (int k = 0; k < 60 && exp.size() != 0; k++) step;
        if (exp.size() != 0) begin numErrors++; closeOut; end
    endtask
    task automatic settle(input int n, input string s);
        writeEnable = 0;
        repeat (2) step;
        `CHK(s, a + n, accCnt)
        drain;
        $display("%s done", s);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tCfg;
        int k;
        `CHK("cfgHigh", 1'b1, configDoneOutput_n)
        configDone_n = 0;
        for (k = 0; k < 10 && configDoneOutput_n !== 1'b0; k++) step;
        `CHK("cfgLag", 3, k)
        if (configDoneOutput_n !== 1'b0) closeOut;
        $display("tCfg done");
    endtask
    task automatic tSel;
        a = accCnt;
        slow = 1;
        sel({deviceId, 4'h1});
        wr(4'h1, 1);
        queueSelectStrobe = 1;
        writeQueueAddress = {deviceId, 4'h3};
        wr(4'h1, 1);
        queueSelectStrobe = 0;
        wr(4'h1, 1);
        wr(4'h3, 1);
        wr(4'h3, 1);
        settle(5, "tSel");
    endtask
    task automatic tBoth;
        a = accCnt;
        queueSelectStrobe = 1;
        flagSectorStrobe = 1;
        writeQueueAddress = {deviceId, 4'h6};
        step;
        queueSelectStrobe = 0;
        flagSectorStrobe = 0;
        step;
        wr(4'h3, 1);
        settle(1, "tBoth");
    endtask
    task automatic tDev;
        a = accCnt;
        sel({deviceId ^ 3'h1, 4'h5});
        wr(4'h5, 0);
        wr(4'h5, 0);
        settle(0, "tDev");
    endtask
    task automatic tFull;
        a = accCnt;
        sel({deviceId, 4'h2});
        stall = 1;
        for (int i = 0; i < 9; i++) wr(4'h2, i < 8);
        writeEnable = 0;
        repeat (2) step;
        `CHK("accFull", a + 8, accCnt)
        `CHK("full", 1'b0, fullFlag_n)
        `CHK("almostFull", 1'b0, almostFullFlag_n)
        `CHK("fxoFull", 1'b0, flagExpansionOutput)
        sec({deviceId, 4'h0}, 8'hfb);
        sec({deviceId, 4'h1}, 8'hff);
        stall = 0;
        drain;
        repeat (8) begin queueDrain = 16'h0004; step; end
        queueDrain = 16'h0;
        repeat (2) step;
        `CHK("fullBack", 1'b1, fullFlag_n)
        `CHK("fxoFree", 1'b1, flagExpansionOutput)
        flagExpansionInput = 0;
        repeat (3) step;
        `CHK("fxoPass", 1'b0, flagExpansionOutput)
        flagExpansionInput = 1;
        $display("tFull done");
    endtask
    task automatic tPoll;
        int n = 0;
        polledMode = 1;
        repeat (6) step;
        repeat (8) begin step; n += flagBusSyncMarker; end
        `CHK("syncCount", 4, n)
        polledMode = 0;
        repeat (6) step;
        `CHK("syncOff", 1'b0, flagBusSyncMarker)
        $display("tPoll done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 rst = 0;
        repeat (2) step;
        tCfg;
        tSel;
        tBoth;
        tDev;
        tFull;
        tPoll;
        closeOut;
    end
endmodule // tb_multiqueue_write_port_select
